// File: include/hws_pkg.sv
package hws_pkg;
	localparam logic [7:0] HWS_CMD_WRITE = 8'hBA;
	localparam logic [7:0] HWS_CMD_READ = 8'hBB;
	localparam logic [15:0] HWS_SETUP_RESET = 16'h2340;
	localparam int HWS_BIT_EXT_PULLUP = 14;
	localparam int HWS_BIT_SLOW_CLK_DIS = 13;
	localparam int HWS_BIT_CLK_KEEP = 12;
	localparam int HWS_DIV_HI = 11;
	localparam int HWS_DIV_LO = 8;
	localparam int HWS_BIT_ACK_ONLY = 7;
	localparam int HWS_BIT_DREQ_POL = 6;
	localparam int HWS_BIT_DACK_POL = 5;
	localparam int HWS_BIT_EOT_POL = 4;
	localparam int HWS_BIT_CS_WAKE = 3;
	localparam int HWS_BIT_PWR_OFF = 2;
	localparam int HWS_BIT_INT_STYLE = 1;
	localparam int HWS_BIT_INT_POL = 0;
	localparam int HWS_CLK_PERIOD_PS = 5000;
	localparam int HWS_SUSPEND_DELAY_US = 2000;
	localparam int HWS_SUSPEND_DELAY_CYC = HWS_SUSPEND_DELAY_US * 1000000 / HWS_CLK_PERIOD_PS;
	localparam int HWS_SLOW_CLK_KHZ = 100;
	localparam int HWS_SLOW_HALF_CYC = 1000000000 / (HWS_SLOW_CLK_KHZ * 2 * HWS_CLK_PERIOD_PS);
	localparam int HWS_INT_PULSE_NS = 166;
	localparam int HWS_INT_PULSE_CYC = (HWS_INT_PULSE_NS * 1000 + HWS_CLK_PERIOD_PS - 1) / HWS_CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		HWS_IDLE = 2'b00,
		HWS_WAIT = 2'b01,
		HWS_SUSP = 2'b10
	} hws_susp_t;
endpackage

// File: logic/hws_setup.sv
`timescale 1ns/1ps
module hws_setup import hws_pkg::*; #(
	parameter int SUSPEND_DELAY = HWS_SUSPEND_DELAY_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_strobe,
	input wire logic [7:0] cmd_code,
	input wire logic data_write_strobe,
	input wire logic [15:0] data_write,
	input wire logic data_read_strobe,
	output logic [15:0] data_read,
	output logic data_read_valid,
	input wire logic usb_bus_reset,
	input wire logic suspend_request,
	input wire logic resume_event,
	input wire logic software_connect_enable,
	input wire logic vbus_present,
	input wire logic chip_select_n,
	input wire logic dma_request_int,
	input wire logic device_dma_ack_in,
	input wire logic end_of_transfer_int,
	input wire logic interrupt_int,
	output logic dplus_pullup_on,
	output logic divided_clock_output,
	output logic core_clock_enable,
	output logic device_suspend_out,
	output logic remote_wakeup,
	output logic device_dma_request_out,
	output logic dma_ack_active,
	output logic end_of_transfer_pin,
	output logic device_interrupt_out
);
	//==========================================
	// command port and register
	logic [15:0] device_hardware_setup;
	logic write_armed;
	logic read_armed;
	wire take_write = data_write_strobe && write_armed;
	wire take_read = data_read_strobe && read_armed;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			write_armed <= 1'b0;
			read_armed <= 1'b0;
		end else if (cmd_strobe) begin
			write_armed <= (cmd_code == HWS_CMD_WRITE);
			read_armed <= (cmd_code == HWS_CMD_READ);
		end else if (data_write_strobe || data_read_strobe) begin
			write_armed <= 1'b0;
			read_armed <= 1'b0;
		end
	end

	// usb bus reset deliberately not in this process
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			device_hardware_setup <= HWS_SETUP_RESET;
		end else if (take_write) begin
			device_hardware_setup <= data_write;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_read <= 16'h0000;
			data_read_valid <= 1'b0;
		end else begin
			data_read_valid <= take_read;
			if (take_read) begin
				data_read <= device_hardware_setup;
			end
		end
	end

	//==========================================
	// field decode
	wire ext_pullup = device_hardware_setup[HWS_BIT_EXT_PULLUP];
	wire slow_clk_dis = device_hardware_setup[HWS_BIT_SLOW_CLK_DIS];
	wire clk_keep = device_hardware_setup[HWS_BIT_CLK_KEEP];
	wire [3:0] div_n = device_hardware_setup[HWS_DIV_HI:HWS_DIV_LO];
	wire ack_only = device_hardware_setup[HWS_BIT_ACK_ONLY];
	wire dreq_pol = device_hardware_setup[HWS_BIT_DREQ_POL];
	wire dack_pol = device_hardware_setup[HWS_BIT_DACK_POL];
	wire eot_pol = device_hardware_setup[HWS_BIT_EOT_POL];
	wire cs_wake = device_hardware_setup[HWS_BIT_CS_WAKE];
	wire pwr_off = device_hardware_setup[HWS_BIT_PWR_OFF];
	wire int_style = device_hardware_setup[HWS_BIT_INT_STYLE];
	wire int_pol = device_hardware_setup[HWS_BIT_INT_POL];

	//==========================================
	// suspend sequencing
	hws_susp_t susp_state;
	hws_susp_t next_susp_state;
	logic susp_req_prev;
	logic [31:0] susp_count;
	wire susp_entry = susp_req_prev && !suspend_request;
	wire in_suspend = (susp_state == HWS_SUSP);
	wire cs_wake_hit = in_suspend && cs_wake && !chip_select_n && vbus_present;
	wire susp_exit = resume_event || cs_wake_hit;

	always_comb begin
		next_susp_state = susp_state;
		case (susp_state)
			HWS_IDLE: begin
				if (susp_entry) next_susp_state = HWS_WAIT;
			end
			HWS_WAIT: begin
				if (resume_event) next_susp_state = HWS_IDLE;
				else if (susp_count == 32'(SUSPEND_DELAY - 1)) next_susp_state = HWS_SUSP;
			end
			HWS_SUSP: begin
				if (susp_exit) next_susp_state = HWS_IDLE;
			end
			default: next_susp_state = HWS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			susp_state <= HWS_IDLE;
			susp_req_prev <= 1'b0;
			susp_count <= 32'h0;
		end else begin
			susp_state <= next_susp_state;
			susp_req_prev <= suspend_request;
			susp_count <= (susp_state == HWS_WAIT) ? susp_count + 32'h1 : 32'h0;
		end
	end

	//==========================================
	// clock output: divided and slow clock
	logic [4:0] div_count;
	logic [3:0] div_active;
	logic div_phase;
	logic [9:0] slow_count;
	logic slow_clk;
	wire [4:0] div_half = {1'b0, div_active} + 5'h01;
	wire div_half_end = (div_count == div_half - 5'h01);
	wire period_end = div_half_end && div_phase;
	wire slow_half_end = (slow_count == 10'(HWS_SLOW_HALF_CYC - 1));
	wire next_clk_out = in_suspend ? (!slow_clk_dis && slow_clk) : div_phase;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_count <= 5'h00;
			div_phase <= 1'b0;
			div_active <= HWS_SETUP_RESET[HWS_DIV_HI:HWS_DIV_LO];
		end else begin
			div_count <= div_half_end ? 5'h00 : div_count + 5'h01;
			if (div_half_end) div_phase <= !div_phase;
			if (period_end) div_active <= div_n;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			slow_count <= 10'h000;
			slow_clk <= 1'b0;
		end else begin
			slow_count <= slow_half_end ? 10'h000 : slow_count + 10'h001;
			if (slow_half_end) slow_clk <= !slow_clk;
		end
	end

	//==========================================
	// interrupt pulse stretcher
	logic int_prev;
	logic [7:0] int_pulse_count;
	wire int_rise = interrupt_int && !int_prev;
	wire int_active = int_style ? (int_pulse_count != 8'h00) : interrupt_int;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			int_prev <= 1'b0;
			int_pulse_count <= 8'h00;
		end else begin
			int_prev <= interrupt_int;
			if (int_rise) int_pulse_count <= 8'(HWS_INT_PULSE_CYC);
			else if (int_pulse_count != 8'h00) int_pulse_count <= int_pulse_count - 8'h01;
		end
	end

	//==========================================
	// registered pins
	wire dreq_active = dma_request_int && !ack_only;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dplus_pullup_on <= 1'b0;
			divided_clock_output <= 1'b0;
			core_clock_enable <= 1'b1;
			device_suspend_out <= 1'b0;
			remote_wakeup <= 1'b0;
			device_dma_request_out <= 1'b0;
			dma_ack_active <= 1'b0;
			end_of_transfer_pin <= 1'b0;
			device_interrupt_out <= 1'b0;
		end else begin
			dplus_pullup_on <= software_connect_enable && !ext_pullup;
			divided_clock_output <= next_clk_out;
			core_clock_enable <= clk_keep || !in_suspend;
			device_suspend_out <= in_suspend && pwr_off;
			remote_wakeup <= cs_wake_hit;
			device_dma_request_out <= dreq_active ~^ dreq_pol;
			dma_ack_active <= device_dma_ack_in ~^ dack_pol;
			end_of_transfer_pin <= end_of_transfer_int ~^ eot_pol;
			device_interrupt_out <= int_active ~^ int_pol;
		end
	end

	//==========================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_write_stores: assert property (take_write |=> device_hardware_setup == $past(data_write))
		else $error("write command did not store data");
	a_read_returns: assert property (take_read |=> data_read_valid && data_read == $past(device_hardware_setup))
		else $error("read returned wrong value");
	a_bus_reset_keeps: assert property (usb_bus_reset && !take_write |=> $stable(device_hardware_setup))
		else $error("bus reset changed setup register");
	a_pullup_external: assert property (ext_pullup |=> !dplus_pullup_on)
		else $error("pullup driven while external pullup selected");
	a_slow_clock_off: assert property (in_suspend && slow_clk_dis |=> !divided_clock_output)
		else $error("slow clock present while disabled");
	a_suspend_delay: assert property (susp_entry && susp_state == HWS_IDLE && !resume_event
		##1 !resume_event [*2] |-> !in_suspend)
		else $error("suspend entered before delay");
	a_clock_stop: assert property (in_suspend && !clk_keep |=> !core_clock_enable)
		else $error("core clock running in suspend");
	a_divider_switch: assert property (!period_end && !rst |=> $stable(div_active))
		else $error("divider changed mid period");
	a_dma_ack_only: assert property (ack_only && !dreq_pol |=> device_dma_request_out)
		else $error("request asserted in ack-only mode");
	a_cs_wakeup: assert property (in_suspend && cs_wake && !chip_select_n && vbus_present |=> remote_wakeup)
		else $error("chip select wake missed");
	a_power_switch: assert property (in_suspend && pwr_off |=> device_suspend_out)
		else $error("power switch not high in suspend");
	a_int_pulse_len: assert property (int_style && int_rise |=> (int_pulse_count != 8'h00) [*8])
		else $error("interrupt pulse too short");
	a_int_polarity: assert property (!int_style |=>
		device_interrupt_out == ($past(interrupt_int) ~^ $past(int_pol)))
		else $error("interrupt polarity wrong");
	c_write_read: cover property (take_write ##[1:20] take_read);
	c_suspend_entry: cover property (susp_entry ##1 (susp_state == HWS_WAIT));
	c_divider_change: cover property (period_end && div_n != div_active);
	c_int_pulse: cover property (int_style && int_rise);
endmodule

// File: testbench/hws_host_model.sv
`timescale 1ns/1ps
module hws_host_model import hws_pkg::*; (
	input wire logic mclk,
	output logic cmd_strobe,
	output logic [7:0] cmd_code,
	output logic data_write_strobe,
	output logic [15:0] data_write,
	output logic data_read_strobe,
	input wire logic [15:0] data_read,
	input wire logic data_read_valid
);
	initial begin
		{cmd_strobe, data_write_strobe, data_read_strobe} = 3'h0;
		cmd_code = 8'h00;
		data_write = 16'h0000;
	end
	// command phase, caller enters just after an edge
	task automatic xfer(input logic [7:0] code);
		cmd_strobe = 1'b1;
		cmd_code = code;
		@(posedge mclk);
		#1;
		cmd_strobe = 1'b0;
		cmd_code = ~code;
	endtask
	task automatic write_word(input logic [15:0] v);
		xfer(HWS_CMD_WRITE);
		data_write_strobe = 1'b1;
		data_write = v;
		@(posedge mclk);
		#1;
		data_write_strobe = 1'b0;
		data_write = ~v;
	endtask
	task automatic read_word(output logic [15:0] v);
		xfer(HWS_CMD_READ);
		data_read_strobe = 1'b1;
		@(posedge mclk);
		#1;
		data_read_strobe = 1'b0;
		v = data_read_valid ? data_read : 16'hXXXX;
	endtask
endmodule

// File: testbench/tb_usb_device_hw_config_register.sv
`timescale 1ns/1ps
module tb_usb_device_hw_config_register import hws_pkg::*;;
	logic mclk = 0, rst = 1, sce = 0, req = 0, ack = 0, eot = 0, irq = 0, ubr = 0, sreq = 0, res = 0, vb = 0, csn = 1;
	logic cs, dws, drs, drv, pu, dco, cce, dso, rwk, dro, daa, eop, dio;
	logic [7:0] cc;
	logic [15:0] dw, dr, w, v;
	int n_mismatch = 0, compares = 0, cycles = 0, n, i;
	always #2.5 mclk = ~mclk;
	hws_host_model host (.mclk(mclk), .cmd_strobe(cs), .cmd_code(cc), .data_write_strobe(dws), .data_write(dw),
		.data_read_strobe(drs), .data_read(dr), .data_read_valid(drv));
	hws_setup #(.SUSPEND_DELAY(20)) DUT (.mclk(mclk), .rst(rst), .cmd_strobe(cs), .cmd_code(cc),
		.data_write_strobe(dws), .data_write(dw), .data_read_strobe(drs), .data_read(dr), .data_read_valid(drv),
		.usb_bus_reset(ubr), .suspend_request(sreq), .resume_event(res), .software_connect_enable(sce),
		.vbus_present(vb), .chip_select_n(csn), .dma_request_int(req), .device_dma_ack_in(ack),
		.end_of_transfer_int(eot), .interrupt_int(irq), .dplus_pullup_on(pu), .divided_clock_output(dco),
		.core_clock_enable(cce), .device_suspend_out(dso), .remote_wakeup(rwk), .device_dma_request_out(dro),
		.dma_ack_active(daa), .end_of_transfer_pin(eop), .device_interrupt_out(dio));
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] exp_pins(input logic [15:0] r);
		return {11'h000, sce & !r[14], (req & !r[7]) ~^ r[6], ack == r[5], eot ~^ r[4], irq ~^ r[0]};
	endfunction
	// length of one high phase of the divided clock
	task automatic high_len(output int k);
		int j;
		k = 0;
		for (j = 0; j < 40 && dco !== 1'b0; j++) cyc(1);
		for (j = 0; j < 40 && dco !== 1'b1; j++) cyc(1);
		for (j = 0; j < 40 && dco === 1'b1; j++) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic give_verdict();
		if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h44fe8caa));
		cyc(6);
		rst = 0;
		host.read_word(v);
		check(v, HWS_SETUP_RESET);
		for (i = 0; i < 10; i++) begin
			w = (i == 0) ? 16'hFFFD : (i == 1) ? 16'h0000 : 16'($urandom) & 16'hFFFD;
			{sce, req, ack, eot, irq} = 5'($urandom);
			host.write_word(w);
			cyc(3);
			check({11'h000, pu, dro, daa, eop, dio}, exp_pins(w));
			ubr = 1;
			cyc(2);
			ubr = 0;
			host.read_word(v);
			check(v, w);
		end
		{sce, req, ack, eot, irq} = 5'h00;
		for (i = 0; i < 3; i++) begin
			w = {4'h0, (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom), 8'h04};
			host.write_word(w);
			high_len(n);
			high_len(n);
			check(16'(n), {12'h000, w[11:8]} + 16'h0001);
		end
		for (i = 0; i < 3; i++) begin
			w = (i == 0) ? 16'h200C : (i == 1) ? 16'h300C : 16'h000C;
			host.write_word(w);
			{vb, csn} = 2'b01;
			sreq = 1;
			cyc(2);
			sreq = 0;
			cyc(30);
			check({14'h0000, cce, dso}, {14'h0000, w[12], 1'b1});
			if (i < 2) begin
				check({15'h0000, dco}, 16'h0000);
			end else begin
				n = 0;
				repeat (2 * HWS_SLOW_HALF_CYC) begin
					cyc(1);
					if (dco === 1'b1) n++;
				end
				check(16'(n), 16'(HWS_SLOW_HALF_CYC));
			end
			if (i == 1) begin
				// clock keep cleared while suspended
				host.write_word(16'h200C);
				cyc(2);
				check({15'h0000, cce}, 16'h0000);
			end
			csn = 0;
			cyc(5);
			check({14'h0000, rwk, dso}, 16'h0001);
			vb = 1;
			cyc(1);
			check({15'h0000, rwk}, 16'h0001);
			cyc(3);
			check({14'h0000, cce, dso}, 16'h0002);
			csn = 1;
		end
		host.write_word(16'h0007);
		cyc(3);
		irq = 1;
		n = 0;
		for (i = 0; i < 80; i++) begin
			cyc(1);
			if (dio === 1'b1) n++;
		end
		check(16'(n), 16'(HWS_INT_PULSE_CYC));
		irq = 0;
		give_verdict();
	end
endmodule
